//--- serial_txrx.sv
/*
  Asynchronous serial transmitter/receiver with an APB register slave.
  Assumes one clock pclk as base clock, async active-low presetn, and that
  serial_in_pin is asynchronous to pclk. The baud divisor counts pclk cycles.
*/
// The APB register port and the placing of the registers are this design's own decisions.
// Functional notes
// - Buffer-full flag is 0 when a byte may be written, 1 otherwise.
// - Shift-active flag is 1 while a frame shifts out, 0 when done.
// - Flags 0 on enable; write sets full; start bit sets active, clears full.
// - Clearing unit or transmit enable resets the transmit circuits.
// - Falling edge starts sampling; start bit accepted if low at mid-bit.
// - Receive disabled: idle, no receive interrupts; buffer kept, but reset to FF when unit enable is cleared.
// - Stop bit detected: buffer loaded and rx-done raised together.
// - Overrun sets flag, keeps old buffer, interrupt follows routing bit.
// - Parity or framing error: finish frame, load buffer, routed interrupt.
// - Receive enable cleared mid-frame aborts with no change and no interrupt.
// - Flags set with interrupt; routing 0 gives error irq, 1 gives done irq.
// - Reading the error status register clears all its flags (not while unit enable is cleared).
// - Parity mismatch, missing stop bit, and unread buffer set errors.
// - Even parity: total ones even; odd count received is an error.
// - Odd parity: total ones odd; even count received is an error.
// - Zero parity: send 0, never check.
// - No parity: no parity bit, no parity error.
// - Input passes inward only after two equal consecutive samples.
// - Filter delays internal receive by up to two clocks.
// - Frame is start, data LSB first, optional parity, stop bits.
// - Tx-done raised as the last stop bit is driven.
`timescale 1ns/1ns
module serial_txrx
  import serial_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk, // APB and base clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic serial_in_pin, // Serial receive line
  output logic serial_out_pin, // Serial transmit line
  output logic tx_done_irq, // Transmit complete pulse
  output logic rx_done_irq, // Receive complete pulse
  output logic rx_error_irq // Receive error pulse
);
  if (ADDR_W < 12) begin : g_chk
    $error("ADDR_W must be at least 12");
  end

  //////////////////////////////////////////////////////////////////////////
  // Register storage and APB decode
  logic [7:0] mode_q;
  logic [7:0] div_q;
  logic [7:0] transmit_buffer_q;
  logic [7:0] receive_buffer_q;
  logic tx_buffer_full_flag_q;
  logic tx_shift_active_flag_q;
  logic parity_error_flag_q;
  logic framing_error_flag_q;
  logic overrun_error_flag_q;
  logic rx_unread_q;
  rx_event_s rx_ev;
  logic access;
  logic wr;
  logic rd;
  logic [11:0] ofs;
  logic mapped;
  logic unit_enable_bit;
  logic tx_enable_bit;
  logic rx_enable_bit;
  logic error_irq_routing_bit;
  parity_e par_mode;
  logic tx_load;
  logic rx_err_any;

  assign ofs = paddr[11:0];
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign mapped = (ofs == OFS_MODE) || (ofs == OFS_TX_STATUS) || (ofs == OFS_RX_ERROR) ||
                  (ofs == OFS_TX_BUF) || (ofs == OFS_RX_BUF) || (ofs == OFS_DIVISOR);
  assign unit_enable_bit = mode_q[MODE_UNIT_EN];
  assign tx_enable_bit = mode_q[MODE_TX_EN];
  assign rx_enable_bit = mode_q[MODE_RX_EN] && unit_enable_bit;
  assign error_irq_routing_bit = mode_q[MODE_ROUTE];
  assign par_mode = parity_e'(mode_q[MODE_PAR_HI:MODE_PAR_LO]);

  // Zero-wait slave: every access completes in its first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // Read mux, registered in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (ofs)
        OFS_MODE: prdata <= {24'h000000, mode_q};
        OFS_TX_STATUS: prdata <= {30'h0, tx_buffer_full_flag_q, tx_shift_active_flag_q};
        OFS_RX_ERROR: prdata <= {29'h0, parity_error_flag_q, framing_error_flag_q,
                                 overrun_error_flag_q};
        OFS_TX_BUF: prdata <= {24'h000000, transmit_buffer_q};
        OFS_RX_BUF: prdata <= {24'h000000, receive_buffer_q};
        OFS_DIVISOR: prdata <= {24'h000000, div_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Mode and divisor; divisor below the minimum is clamped for safety
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RESET;
      div_q <= DIV_RESET;
    end else if (wr && pstrb[0] && pready) begin
      if (ofs == OFS_MODE) begin
        mode_q <= pwdata[7:0];
      end
      if (ofs == OFS_DIVISOR) begin
        div_q <= (pwdata[7:0] < DIV_MIN) ? DIV_MIN : pwdata[7:0];
      end
    end
  end

  // Writes are ignored while transmit is disabled
  assign tx_load = wr && pready && pstrb[0] && (ofs == OFS_TX_BUF) &&
                   unit_enable_bit && tx_enable_bit;

  //////////////////////////////////////////////////////////////////////////
  // Transmitter
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
  tx_state_e tx_st_q;
  logic [8:0] tx_cnt_q;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_bit_q;
  logic tx_par_q;
  logic tx_bit_end;
  logic [2:0] last_bit;
  logic tx_run;

  assign tx_run = unit_enable_bit && tx_enable_bit;
  assign last_bit = mode_q[MODE_CHAR8] ? 3'd7 : 3'd6;
  // One bit lasts 2*k base clocks
  assign tx_bit_end = (tx_cnt_q == {div_q, 1'b0} - 9'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_buffer_q <= BUF_RESET;
      tx_buffer_full_flag_q <= 1'b0;
    end else if (!tx_run) begin
      tx_buffer_full_flag_q <= 1'b0;
    end else if (tx_load) begin
      transmit_buffer_q <= pwdata[7:0];
      tx_buffer_full_flag_q <= 1'b1;
    end else if (tx_buffer_full_flag_q && (tx_st_q == TX_IDLE ||
             (tx_st_q == TX_STOP && tx_bit_end && tx_bit_q[0] == mode_q[MODE_STOP2]))) begin
      tx_buffer_full_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 9'd0;
      tx_sh_q <= 8'h00;
      tx_bit_q <= 3'd0;
      tx_par_q <= 1'b0;
      serial_out_pin <= 1'b1;
      tx_shift_active_flag_q <= 1'b0;
      tx_done_irq <= 1'b0;
    end else begin
      tx_done_irq <= 1'b0;
      tx_cnt_q <= tx_bit_end ? 9'd0 : tx_cnt_q + 9'd1;
      if (!tx_run) begin
        tx_st_q <= TX_IDLE;
        serial_out_pin <= 1'b1;
        tx_shift_active_flag_q <= 1'b0;
      end else begin
        unique case (tx_st_q)
          TX_IDLE: begin
            tx_cnt_q <= 9'd0;
            if (tx_buffer_full_flag_q) begin
              tx_st_q <= TX_START;
              tx_sh_q <= transmit_buffer_q;
              tx_par_q <= (par_mode == PAR_ODD) ? ~^transmit_buffer_q[6:0] ^
                          (mode_q[MODE_CHAR8] & transmit_buffer_q[7]) :
                          ^transmit_buffer_q[6:0] ^
                          (mode_q[MODE_CHAR8] & transmit_buffer_q[7]);
              serial_out_pin <= 1'b0;
              tx_shift_active_flag_q <= 1'b1;
            end
          end
          TX_START: if (tx_bit_end) begin
            tx_st_q <= TX_DATA;
            tx_bit_q <= 3'd0;
            serial_out_pin <= tx_sh_q[0];
          end
          TX_DATA: if (tx_bit_end) begin
            tx_sh_q <= {1'b1, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q + 3'd1;
            if (tx_bit_q == last_bit) begin
              tx_bit_q <= 3'd0;
              if (par_mode == PAR_NONE) begin
                tx_st_q <= TX_STOP;
                serial_out_pin <= 1'b1;
                tx_done_irq <= !mode_q[MODE_STOP2];
              end else begin
                tx_st_q <= TX_PAR;
                serial_out_pin <= (par_mode == PAR_ZERO) ? 1'b0 : tx_par_q;
              end
            end else begin
              serial_out_pin <= tx_sh_q[1];
            end
          end
          TX_PAR: if (tx_bit_end) begin
            tx_st_q <= TX_STOP;
            serial_out_pin <= 1'b1;
            tx_done_irq <= !mode_q[MODE_STOP2];
          end
          TX_STOP: if (tx_bit_end) begin
            if (tx_bit_q[0] != mode_q[MODE_STOP2]) begin
              tx_bit_q <= 3'd1;
              tx_done_irq <= 1'b1;
            end else if (tx_buffer_full_flag_q) begin
              // Back-to-back frame: reload immediately
              tx_st_q <= TX_START;
              tx_sh_q <= transmit_buffer_q;
              tx_par_q <= (par_mode == PAR_ODD) ? ~^transmit_buffer_q[6:0] ^
                          (mode_q[MODE_CHAR8] & transmit_buffer_q[7]) :
                          ^transmit_buffer_q[6:0] ^
                          (mode_q[MODE_CHAR8] & transmit_buffer_q[7]);
              serial_out_pin <= 1'b0;
            end else begin
              tx_st_q <= TX_IDLE;
              tx_shift_active_flag_q <= 1'b0;
            end
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive input synchroniser and two-sample noise filter
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_samp_q;
  logic rx_filt_q;
  logic rx_filt_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_samp_q <= 1'b1;
      rx_filt_q <= 1'b1;
      rx_filt_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= serial_in_pin;
      rx_sync_q <= rx_meta_q;
      rx_samp_q <= rx_sync_q;
      if (rx_sync_q == rx_samp_q) begin
        rx_filt_q <= rx_samp_q;
      end
      rx_filt_prev_q <= rx_filt_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;
  rx_state_e rx_st_q;
  logic [8:0] rx_cnt_q;
  logic [7:0] rx_sh_q;
  logic [2:0] rx_bit_q;
  logic rx_mid;
  logic rx_pe_q;

  assign rx_mid = (rx_cnt_q == {1'b0, div_q} - 9'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 9'd0;
      rx_sh_q <= 8'h00;
      rx_bit_q <= 3'd0;
      rx_pe_q <= 1'b0;
      rx_ev <= '0;
    end else begin
      rx_ev.done <= 1'b0;
      rx_cnt_q <= (rx_cnt_q == {div_q, 1'b0} - 9'd1) ? 9'd0 : rx_cnt_q + 9'd1;
      if (!rx_enable_bit) begin
        rx_st_q <= RX_IDLE;
      end else begin
        unique case (rx_st_q)
          RX_IDLE: if (rx_filt_prev_q && !rx_filt_q) begin
            rx_st_q <= RX_START;
            rx_cnt_q <= 9'd0;
          end
          RX_START: if (rx_mid) begin
            // Back off one bit period so rx_mid recurs every 2*k clocks for k up to 170, no drift
            rx_cnt_q <= 9'd0 - {1'b0, div_q};
            rx_bit_q <= 3'd0;
            rx_pe_q <= 1'b0;
            rx_sh_q <= 8'h00;
            rx_st_q <= rx_filt_q ? RX_IDLE : RX_DATA;
          end
          RX_DATA: if (rx_mid) begin
            rx_cnt_q <= 9'd0 - {1'b0, div_q};
            rx_sh_q <= mode_q[MODE_CHAR8] ? {rx_filt_q, rx_sh_q[7:1]} :
                       {1'b0, rx_filt_q, rx_sh_q[6:1]};
            rx_pe_q <= rx_pe_q ^ rx_filt_q;
            rx_bit_q <= rx_bit_q + 3'd1;
            if (rx_bit_q == last_bit) begin
              rx_st_q <= (par_mode == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
          RX_PAR: if (rx_mid) begin
            rx_cnt_q <= 9'd0 - {1'b0, div_q};
            rx_pe_q <= rx_pe_q ^ rx_filt_q;
            rx_st_q <= RX_STOP;
          end
          RX_STOP: if (rx_mid) begin
            rx_st_q <= RX_IDLE;
            rx_ev.done <= 1'b1;
            rx_ev.data <= rx_sh_q;
            rx_ev.frm_err <= !rx_filt_q;
            rx_ev.par_err <= ((par_mode == PAR_EVEN) && rx_pe_q) ||
                             ((par_mode == PAR_ODD) && !rx_pe_q);
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive buffer, error flags and receive interrupts
  logic rx_ovr;
  logic rx_err_rd;
  logic rx_buf_rd;

  assign rx_err_rd = rd && pready && (ofs == OFS_RX_ERROR);
  assign rx_buf_rd = rd && pready && (ofs == OFS_RX_BUF);
  assign rx_ovr = rx_unread_q && !rx_buf_rd;
  assign rx_err_any = rx_ev.par_err || rx_ev.frm_err || rx_ovr;

  // Set beats the read-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer_q <= BUF_RESET;
      rx_unread_q <= 1'b0;
      parity_error_flag_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      rx_done_irq <= 1'b0;
      rx_error_irq <= 1'b0;
    end else if (!unit_enable_bit) begin
      receive_buffer_q <= BUF_RESET;
      rx_unread_q <= 1'b0;
      rx_done_irq <= 1'b0;
      rx_error_irq <= 1'b0;
    end else begin
      rx_done_irq <= 1'b0;
      rx_error_irq <= 1'b0;
      if (rx_buf_rd) begin
        rx_unread_q <= 1'b0;
      end
      if (rx_err_rd) begin
        parity_error_flag_q <= 1'b0;
        framing_error_flag_q <= 1'b0;
        overrun_error_flag_q <= 1'b0;
      end
      if (rx_ev.done && rx_enable_bit) begin
        if (!rx_ovr) begin
          receive_buffer_q <= rx_ev.data;
          rx_unread_q <= 1'b1;
        end
        if (rx_ev.par_err) parity_error_flag_q <= 1'b1;
        if (rx_ev.frm_err) framing_error_flag_q <= 1'b1;
        if (rx_ovr) overrun_error_flag_q <= 1'b1;
        rx_done_irq <= !rx_err_any || error_irq_routing_bit;
        rx_error_irq <= rx_err_any && !error_irq_routing_bit;
      end
    end
  end
endmodule

//--- serial_pkg.sv
/*
  Shared constants and types for the asynchronous serial transceiver core.
  Assumes a 32-bit APB master on pclk; register offsets are byte addresses.
*/
package serial_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_TX_STATUS = 12'h004;
  localparam logic [11:0] OFS_RX_ERROR = 12'h008;
  localparam logic [11:0] OFS_TX_BUF = 12'h00C;
  localparam logic [11:0] OFS_RX_BUF = 12'h010;
  localparam logic [11:0] OFS_DIVISOR = 12'h014;
  // Mode register field positions
  localparam int MODE_UNIT_EN = 7;
  localparam int MODE_TX_EN = 6;
  localparam int MODE_RX_EN = 5;
  localparam int MODE_PAR_HI = 4;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_CHAR8 = 2;
  localparam int MODE_STOP2 = 1;
  localparam int MODE_ROUTE = 0;
  // Status field positions
  localparam int STAT_BUF_FULL = 1;
  localparam int STAT_SHIFT_ACT = 0;
  localparam int ERR_PAR = 2;
  localparam int ERR_FRM = 1;
  localparam int ERR_OVR = 0;
  // Reset values and the divisor minimum
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] BUF_RESET = 8'hFF;
  localparam logic [7:0] DIV_RESET = 8'hFF;
  localparam logic [7:0] DIV_MIN = 8'h08;
  // Parity modes
  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_ZERO = 2'b01, PAR_ODD = 2'b10,
                            PAR_EVEN = 2'b11} parity_e;
  // Receive completion event carried to the status logic
  typedef struct packed {
    logic done;
    logic par_err;
    logic frm_err;
    logic [7:0] data;
  } rx_event_s;
endpackage

//--- serial_txrx_asserts.sv
/*
  Port checker for the serial transceiver, bound to serial_txrx.
  Assumes one clock pclk and the async active-low presetn.
*/
`timescale 1ns/1ns
module serial_txrx_asserts
  import serial_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic serial_in_pin, // Receive line
  input wire logic serial_out_pin, // Transmit line
  input wire logic tx_done_irq, // Transmit done
  input wire logic rx_done_irq, // Receive done
  input wire logic rx_error_irq // Receive error
);
  logic acc_w;
  logic rx_en_q;
  logic tx_en_q;
  logic clr_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed access to a mapped register
  assign acc_w = psel && penable && pready && !pslverr;
  // Mirror of the enables written to the mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (acc_w && pwrite && pstrb[0] && paddr == ADDR_W'(OFS_MODE)) begin
      rx_en_q <= pwdata[MODE_UNIT_EN] && pwdata[MODE_RX_EN];
      tx_en_q <= pwdata[MODE_UNIT_EN] && pwdata[MODE_TX_EN];
    end
  end
  // Set after an error-status read; a new frame may set flags again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_q <= 1'b0;
    end else if (rx_done_irq || rx_error_irq) begin
      clr_q <= 1'b0;
    end else if (acc_w && !pwrite && paddr == ADDR_W'(OFS_RX_ERROR)) begin
      clr_q <= 1'b1;
    end
  end
  bus_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_phase_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  irq_excl_a: assert property (rx_error_irq |-> !rx_done_irq)
    else $error("both receive interrupts");
  txdone_stop_a: assert property (tx_done_irq |-> serial_out_pin [*8])
    else $error("transmit done not on stop bit");
  rx_quiet_a: assert property (!rx_en_q && !$past(rx_en_q) && !$past(rx_en_q, 2)
    |-> !rx_done_irq && !rx_error_irq) else $error("receive interrupt while off");
  tx_idle_a: assert property (!tx_en_q && !$past(tx_en_q) && !$past(tx_en_q, 2)
    |-> serial_out_pin) else $error("line not idle while off");
  err_clear_a: assert property (acc_w && !pwrite && paddr == ADDR_W'(OFS_RX_ERROR)
    && clr_q && !rx_done_irq && !rx_error_irq |-> prdata == 32'h0)
    else $error("error status not cleared by read");
endmodule
bind serial_txrx serial_txrx_asserts #(.ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
  .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));

//--- serial_line_partner.sv
/*
  Remote transceiver model on the serial line.
  Assumes 8-bit characters, one stop bit, line idle high.
*/
`timescale 1ns/1ns
module serial_line_partner
  import serial_pkg::*;
#(
  parameter int BIT_CYC = 16
) (
  input wire logic pclk, // Base clock
  input wire logic from_dut, // Device transmit line
  input wire parity_e par_mode, // Parity in use
  output logic to_dut // Device receive line
);
  logic [8:0] got_q[$]; // Captured frames, parity in bit 8
  logic [8:0] fr;
  initial to_dut = 1'b1;
  // Capture frames mid-bit, LSB first
  always begin
    @(negedge from_dut);
    repeat (BIT_CYC / 2) @(posedge pclk);
    fr = '0;
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      if (i < 8 || par_mode != PAR_NONE) fr[i] = from_dut;
    end
    // Stop here, mid tail bit, so a back-to-back start edge is still seen
    got_q.push_back(fr);
  end
  // One bit period on the line
  task automatic drive(input logic b);
    to_dut <= b;
    repeat (BIT_CYC) @(posedge pclk);
  endtask
  // Frame with optional parity or stop fault
  task automatic send(input logic [7:0] d, input logic bp, input logic bs);
    logic p;
    p = (par_mode == PAR_EVEN) ? ^d : (par_mode == PAR_ODD) ? ~^d : 1'b0;
    drive(1'b0);
    for (int i = 0; i < 8; i++) drive(d[i]);
    if (par_mode != PAR_NONE) drive(p ^ bp);
    drive(~bs);
    to_dut <= 1'b1;
    @(posedge pclk);
  endtask
  // Low for one clock only
  task automatic glitch();
    to_dut <= 1'b0;
    @(posedge pclk);
    to_dut <= 1'b1;
    @(posedge pclk);
  endtask
endmodule

//--- async_serial_txrx_core_tb_top.sv
/*
  Testbench: APB tasks drive the transceiver, a line partner talks to it.
  Assumes divisor 8, so one bit is 16 clocks.
*/
`timescale 1ns/1ns
module async_serial_txrx_core_tb_top
  import serial_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, se, sin, sout, txd, rxd, rxe;
  parity_e pm = PAR_NONE;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_txd = 0;
  int n_rxd = 0;
  int n_rxe = 0;
  int a;
  always #10 pclk = ~pclk;
  serial_txrx dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in_pin(sin), .serial_out_pin(sout),
    .tx_done_irq(txd), .rx_done_irq(rxd), .rx_error_irq(rxe));
  serial_line_partner #(.BIT_CYC(16)) partner_u (.pclk(pclk), .from_dut(sout),
    .par_mode(pm), .to_dut(sin));
  ////////////////////////////////////////////////////////////////////////////////
  // Pulse counters and the hang limit
  always @(posedge pclk) begin
    cyc++;
    n_txd += txd;
    n_rxd += rxd;
    n_rxe += rxe;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer; idles a cycle after so strobes never toggle twice at once
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Waits on pready alone; only the cycle ceiling ends a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_rx(input int n0);
    for (int t = 0; t < 200 && n_rxd + n_rxe == n0; t++) @(posedge pclk);
  endtask
  // Receive one frame, then check pulses, error status and buffer
  task automatic rx_case(input logic [7:0] d, input logic bp, input logic bs,
      input int ed, input int ee, input logic [31:0] ef, input logic [31:0] eb);
    int d0, e0;
    d0 = n_rxd;
    e0 = n_rxe;
    partner_u.send(d, bp, bs);
    wait_rx(d0 + e0);
    @(posedge pclk);
    chk(n_rxd - d0, ed);
    chk(n_rxe - e0, ee);
    apb(1'b0, OFS_RX_ERROR, 32'h0);
    chk(rd, ef);
    apb(1'b0, OFS_RX_BUF, 32'h0);
    chk(rd, eb);
  endtask
  // Two bytes back to back, polling the buffer-full flag
  task automatic tx_pair(input logic [7:0] b0, input logic [7:0] b1);
    int t, n0;
    n0 = n_txd;
    apb(1'b1, OFS_TX_BUF, {24'h0, b0});
    rd = 32'h2;
    for (t = 0; t < 100 && rd[STAT_BUF_FULL] !== 1'b0; t++) apb(1'b0, OFS_TX_STATUS, 0);
    apb(1'b1, OFS_TX_BUF, {24'h0, b1});
    apb(1'b0, OFS_TX_STATUS, 32'h0);
    chk(rd, 32'h3);
    for (t = 0; t < 1000 && n_txd - n0 < 2; t++) @(posedge pclk);
    apb(1'b0, OFS_TX_STATUS, 32'h0);
    chk(rd, 32'h1);
    for (t = 0; t < 100 && rd[STAT_SHIFT_ACT] !== 1'b0; t++) apb(1'b0, OFS_TX_STATUS, 0);
    chk(rd, 32'h0);
    repeat (16) @(posedge pclk);
    chk(partner_u.got_q.size(), 2);
    for (t = 0; t < 2; t++) chk(partner_u.got_q.pop_front(), {parb(t ? b1 : b0), t ? b1 : b0});
  endtask
  function automatic logic parb(input logic [7:0] d);
    return pm == PAR_EVEN ? ^d : pm == PAR_ODD ? ~^d : 1'b0;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_MODE, 32'h0);
    chk(rd, 32'h01);
    apb(1'b0, OFS_RX_BUF, 32'h0);
    chk(rd, 32'hFF);
    apb(1'b0, 12'h018, 32'h0);
    chk(se, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, OFS_DIVISOR, 32'h8);
    apb(1'b1, OFS_MODE, 32'h80);
    $display("reset values done");
    for (int p = 0; p < 4; p++) begin
      pm = parity_e'(p);
      apb(1'b1, OFS_MODE, 32'hE4 | (p << 3));
      apb(1'b0, OFS_TX_STATUS, 32'h0);
      chk(rd, 32'h0);
      tx_pair(8'hA5 ^ p[7:0], 8'h3C + p[7:0]);
      rx_case(8'h96 - p[7:0], 1'b0, 1'b0, 1, 0, 32'h0, 32'h96 - p);
      rx_case(8'h69, 1'b1, 1'b0, p > 1 ? 0 : 1, p > 1, p > 1 ? 32'h4 : 0, 32'h69);
      $display("parity mode %0d done", p);
    end
    apb(1'b0, OFS_RX_ERROR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFS_MODE, 32'hFD);
    rx_case(8'h33, 1'b0, 1'b1, 1, 0, 32'h2, 32'h33);
    partner_u.send(8'h11, 1'b0, 1'b0);
    rx_case(8'h22, 1'b0, 1'b0, 1, 0, 32'h1, 32'h11);
    $display("error cases done");
    a = n_rxd + n_rxe;
    partner_u.glitch();
    wait_rx(a);
    chk(n_rxd + n_rxe, a);
    fork
      partner_u.send(8'h77, 1'b0, 1'b0);
      begin
        repeat (60) @(posedge pclk);
        apb(1'b1, OFS_MODE, 32'hDD);
      end
    join
    rx_case(8'h44, 1'b0, 1'b0, 0, 0, 32'h0, 32'h11);
    // Seven-bit characters, two stop bits: done pulse only on the second stop
    pm = PAR_NONE;
    apb(1'b1, OFS_MODE, 32'hC2);
    a = n_txd;
    apb(1'b1, OFS_TX_BUF, 32'h2B);
    repeat (140) @(posedge pclk);
    chk(n_txd - a, 0);
    repeat (60) @(posedge pclk);
    chk(n_txd - a, 1);
    chk(partner_u.got_q.pop_front(), 32'h0AB);
    // Transmit disabled mid-frame: flags drop, line idles, writes ignored
    apb(1'b1, OFS_TX_BUF, 32'h55);
    repeat (40) @(posedge pclk);
    apb(1'b1, OFS_MODE, 32'h80);
    apb(1'b1, OFS_TX_BUF, 32'h5A);
    apb(1'b0, OFS_TX_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk(sout, 1'b1);
    chk(n_txd - a, 1);
    $display("abort and disable done");
    results();
  end
endmodule
